// >>> rss_pkg.sv
// Package with register map and field constants for the reset strap sampler
package rss_pkg;
   localparam logic [31:0] RSS_STRAP_OFS    = 32'h0000_0000;
   localparam logic [31:0] RSS_COMMAND_OFS  = 32'h0000_0004;
   localparam logic [31:0] RSS_MISC_TWO_OFS = 32'h0000_0008;
   localparam logic [31:0] RSS_LIVE_OFS     = 32'h0000_000c;
   localparam logic [3:0]  RSS_ADDR_LSB     = 4'h2;
   localparam logic [3:0]  RSS_ADDR_MSB     = 4'h3;
   // Field positions in the captured strap register
   localparam int RSS_F_BURST  = 0;
   localparam int RSS_F_SIZE1  = 1;
   localparam int RSS_F_MEN    = 2;
   localparam int RSS_F_ARB    = 3;
   localparam int RSS_F_OFF    = 4;
   localparam int RSS_F_SDA    = 5;
   localparam int RSS_F_EEP    = 6;
   localparam int RSS_F_TMODE  = 7;
   localparam int RSS_NSTRAP   = 9;
   // Field positions in command and misc-control-two registers
   localparam int RSS_F_MASTER = 2;
   localparam int RSS_F_OFFSTS = 0;
   localparam logic [RSS_NSTRAP-1:0] RSS_STRAP_RST = 9'h000;
   localparam logic [1:0] RSS_RESP_OKAY   = 2'h0;
   localparam logic [1:0] RSS_RESP_SLVERR = 2'h2;
   localparam logic [1:0] RSS_TMODE_NORMAL = 2'h0;
endpackage

// >>> rss_reset_strap_sampler.sv
// Reset strap sampler: captures configuration straps at reset release, AXI4-Lite registers
// Notes on behaviour
// [RULE1] All straps are captured on the rise of the PCI reset, the rise of the local reset and the fall of hot-swap healthy.
// [RULE2] A burst-in-progress strap captured low selects the 68360-style local master protocol.
// [RULE3] 68360-style local slave cycles are accepted whatever the captured size bit 1 strap.
// [RULE4] A nonzero test-mode select puts the device in tri-state or NAND-tree test; open inputs read low for normal work.
// [RULE5] A master-enable strap high during PCI reset sets the bus-master enable bit in the command register.
// [RULE6] With the master-enable strap low, software must write the command register to enable bus mastering.
// [RULE7] An arbiter-enable strap captured high enables the internal PCI arbiter, otherwise it stays off.
// [RULE8] An interface-disable strap captured high disables the PCI interface and sets the disable status bit.
// [RULE9] While the disable status bit is set, every PCI target access is retried until software clears it.
// [RULE10] The board holds serial data and EEPROM-enable straps high when an EEPROM is fitted, serial data low otherwise.
// [RULE11] Captured straps hold steady until the next qualifying reset edge.
`timescale 1ns/1ps
module rss_reset_strap_sampler
   import rss_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic        pciResetn,
   input  wire logic        localResetn,
   input  wire logic        hotSwapHealthyn,
   input  wire logic        burstInProgressStrapn,
   input  wire logic        sizeBit1Strap,
   input  wire logic [1:0]  testModeSelect,
   input  wire logic        masterEnableStrap,
   input  wire logic        arbiterEnableStrap,
   input  wire logic        hostPortOffStrap,
   input  wire logic        serialDataStrap,
   input  wire logic        eepromLoadStrap,
   input  wire logic        pciTargetRequest,
   output logic             pciTargetRetry,
   output logic             localMaster68360,
   output logic             localSlave68360,
   output logic             testModeActive,
   output logic [1:0]       testModeCode,
   output logic             pciMasterEnable,
   output logic             arbiterEnable,
   output logic             pciInterfaceOff,
   output logic             eepromLoadEnable,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   localparam int NSYNC = 3 + RSS_NSTRAP;

   // Two-flop synchronisers for every pin input
   logic [NSYNC-1:0]      syncA_q;
   logic [NSYNC-1:0]      syncB_q;
   logic [2:0]            rstPrev_q;
   logic [RSS_NSTRAP-1:0] strap_q;
   logic                  master_q;
   logic                  offSts_q;
   logic                  retry_q;
   logic                  awHeld_q;
   logic                  wHeld_q;
   logic [31:0]           awAddr_q;
   logic [31:0]           wData_q;
   logic [3:0]            wStrb_q;
   logic                  bValid_q;
   logic [1:0]            bResp_q;
   logic                  rValid_q;
   logic [31:0]           rData_q;
   logic [1:0]            rResp_q;

   wire [NSYNC-1:0] pinIn = {testModeSelect, eepromLoadStrap, serialDataStrap, hostPortOffStrap,
                             arbiterEnableStrap, masterEnableStrap, sizeBit1Strap, burstInProgressStrapn,
                             pciTargetRequest, hotSwapHealthyn, localResetn};
   wire [RSS_NSTRAP-1:0] strapNow = syncB_q[NSYNC-1:3];
   wire localRstS = syncB_q[0];
   wire healthyS  = syncB_q[1];
   wire pciReqS   = syncB_q[2];

   // PCI reset is itself asynchronous; it is resynchronised on its own two-flop chain, pciRst_q
   logic [1:0] pciRst_q;
   wire pciRstS = pciRst_q[1];

   wire pciRise   = pciRstS & ~rstPrev_q[0];
   wire localRise = localRstS & ~rstPrev_q[1];
   wire healthyFall = ~healthyS & rstPrev_q[2];
   wire captureNow = pciRise | localRise | healthyFall; // [RULE1]

   // AXI write decode
   wire awFire = s_axi_awvalid & s_axi_awready;
   wire wFire  = s_axi_wvalid & s_axi_wready;
   wire haveAw = awHeld_q | awFire;
   wire haveW  = wHeld_q | wFire;
   wire [31:0] wAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
   wire [31:0] wData = wHeld_q ? wData_q : s_axi_wdata;
   wire [3:0]  wStrb = wHeld_q ? wStrb_q : s_axi_wstrb;
   wire doWrite = haveAw & haveW & ~bValid_q;
   wire wInRange = wAddr[31:RSS_ADDR_MSB+1] == 28'h0000000 && wAddr[1:0] == 2'h0;
   wire wrCommand = doWrite & wInRange & wAddr[RSS_ADDR_MSB:RSS_ADDR_LSB] == RSS_COMMAND_OFS[3:2];
   wire wrMiscTwo = doWrite & wInRange & wAddr[RSS_ADDR_MSB:RSS_ADDR_LSB] == RSS_MISC_TWO_OFS[3:2];
   wire wrReadOnly = doWrite & wInRange &
                     (wAddr[RSS_ADDR_MSB:RSS_ADDR_LSB] == RSS_STRAP_OFS[3:2] ||
                      wAddr[RSS_ADDR_MSB:RSS_ADDR_LSB] == RSS_LIVE_OFS[3:2]);
   wire wrOk = wrCommand | wrMiscTwo | wrReadOnly;

   // AXI read decode
   wire arFire = s_axi_arvalid & s_axi_arready;
   wire rInRange = s_axi_araddr[31:RSS_ADDR_MSB+1] == 28'h0000000 && s_axi_araddr[1:0] == 2'h0;
   wire [1:0] rSel = s_axi_araddr[RSS_ADDR_MSB:RSS_ADDR_LSB];
   logic [31:0] rMux;
   always_comb begin
      rMux = 32'h0000_0000;
      unique case (rSel)
         RSS_STRAP_OFS[3:2]:    rMux = {23'h000000, strap_q};
         RSS_COMMAND_OFS[3:2]:  rMux = {29'h00000000, master_q, 2'h0};
         RSS_MISC_TWO_OFS[3:2]: rMux = {31'h00000000, offSts_q};
         RSS_LIVE_OFS[3:2]:     rMux = {23'h000000, strapNow};
      endcase
   end

   assign s_axi_awready = ~awHeld_q & ~bValid_q;
   assign s_axi_wready  = ~wHeld_q & ~bValid_q;
   assign s_axi_bvalid  = bValid_q;
   assign s_axi_bresp   = bResp_q;
   assign s_axi_arready = ~rValid_q;
   assign s_axi_rvalid  = rValid_q;
   assign s_axi_rdata   = rData_q;
   assign s_axi_rresp   = rResp_q;

   // Decoded modes; protocol, test, arbiter and EEPROM outputs come from the captured straps, slave style is fixed
   assign localMaster68360 = ~strap_q[RSS_F_BURST]; // [RULE2]
   assign localSlave68360  = 1'b1; // [RULE3]
   assign testModeCode     = strap_q[RSS_F_TMODE +: 2];
   assign testModeActive   = testModeCode != RSS_TMODE_NORMAL; // [RULE4]
   assign pciMasterEnable  = master_q;
   assign arbiterEnable    = strap_q[RSS_F_ARB]; // [RULE7]
   assign pciInterfaceOff  = offSts_q; // [RULE8]
   // Serial-data and EEPROM straps both high means an EEPROM load is wanted
   assign eepromLoadEnable = strap_q[RSS_F_EEP] & strap_q[RSS_F_SDA]; // [RULE10]
   assign pciTargetRetry   = retry_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         syncA_q   <= '0;
         syncB_q   <= '0;
         pciRst_q  <= 2'h0;
         rstPrev_q <= 3'h0;
      end else begin
         syncA_q   <= pinIn;
         syncB_q   <= syncA_q;
         pciRst_q  <= {pciRst_q[0], pciResetn};
         rstPrev_q <= {healthyS, localRstS, pciRstS};
      end
   end

   // Straps freeze between reset edges; live changes are ignored
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         strap_q <= RSS_STRAP_RST;
      end else if (captureNow) begin
         strap_q <= strapNow; // [RULE11]
      end
   end

   // Master enable follows the strap while PCI reset is held; software may set it afterwards
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         master_q <= 1'b0;
      end else if (!pciRstS) begin
         master_q <= strapNow[RSS_F_MEN]; // [RULE5]
      end else if (wrCommand && wStrb[0]) begin
         master_q <= wData[RSS_F_MASTER]; // [RULE6]
      end
   end

   // Strap capture loads the off status from the strap; a write of one clears it, capture wins a tie
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         offSts_q <= 1'b0;
      end else if (captureNow) begin
         offSts_q <= strapNow[RSS_F_OFF]; // [RULE8]
      end else if (wrMiscTwo && wStrb[0] && wData[RSS_F_OFFSTS]) begin
         offSts_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         retry_q <= 1'b0;
      end else begin
         retry_q <= pciReqS & offSts_q; // [RULE9]
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         awHeld_q <= 1'b0;
         wHeld_q  <= 1'b0;
         awAddr_q <= 32'h0000_0000;
         wData_q  <= 32'h0000_0000;
         wStrb_q  <= 4'h0;
         bValid_q <= 1'b0;
         bResp_q  <= RSS_RESP_OKAY;
      end else begin
         if (doWrite) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            bValid_q <= 1'b1;
            bResp_q  <= wrOk ? RSS_RESP_OKAY : RSS_RESP_SLVERR;
         end else begin
            if (awFire) begin
               awHeld_q <= 1'b1;
               awAddr_q <= s_axi_awaddr;
            end
            if (wFire) begin
               wHeld_q <= 1'b1;
               wData_q <= s_axi_wdata;
               wStrb_q <= s_axi_wstrb;
            end
            if (bValid_q && s_axi_bready) begin
               bValid_q <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rValid_q <= 1'b0;
         rData_q  <= 32'h0000_0000;
         rResp_q  <= RSS_RESP_OKAY;
      end else if (arFire) begin
         rValid_q <= 1'b1;
         rData_q  <= rInRange ? rMux : 32'h0000_0000;
         rResp_q  <= rInRange ? RSS_RESP_OKAY : RSS_RESP_SLVERR;
      end else if (rValid_q && s_axi_rready) begin
         rValid_q <= 1'b0;
      end
   end
endmodule

// >>> rss_board_model.sv
// Board side model: strap resistors and EEPROM fitting
`timescale 1ns/1ps
module rss_board_model
   import rss_pkg::*;
(
   input  wire logic [RSS_NSTRAP-1:0] pick,
   input  wire logic                  fitted,
   output logic      [RSS_NSTRAP-1:0] straps
);
   // Unpicked pins other than serial data and EEPROM read as pull-downs, so master enable left open needs software
   always_comb begin
      straps = pick;
      straps[RSS_F_SDA] = fitted;
      straps[RSS_F_EEP] = fitted;
   end
endmodule

// >>> rss_strap_sva.sv
// Assertion checker for the reset strap sampler ports
`timescale 1ns/1ps
module rss_strap_sva (
   input wire logic       clk_sys,
   input wire logic       resetn,
   input wire logic       pciResetn,
   input wire logic       localResetn,
   input wire logic       hotSwapHealthyn,
   input wire logic       burstInProgressStrapn,
   input wire logic       masterEnableStrap,
   input wire logic       arbiterEnableStrap,
   input wire logic       hostPortOffStrap,
   input wire logic       pciTargetRequest,
   input wire logic       pciTargetRetry,
   input wire logic       localMaster68360,
   input wire logic       localSlave68360,
   input wire logic       testModeActive,
   input wire logic [1:0] testModeCode,
   input wire logic       pciMasterEnable,
   input wire logic       arbiterEnable,
   input wire logic       pciInterfaceOff,
   input wire logic       eepromLoadEnable
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   logic [2:0] pinsQ;
   logic [3:0] quietQ;
   // Cycles since the last change on any reset pin
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pinsQ <= 3'h0;
         quietQ <= 4'h0;
      end else begin
         pinsQ <= {pciResetn, localResetn, hotSwapHealthyn};
         quietQ <= (pinsQ != {pciResetn, localResetn, hotSwapHealthyn}) ? 4'h0 : quietQ + {3'h0, quietQ != 4'hf};
      end
   end
   chk_slave_always: assert property (localSlave68360) else $error("slave style dropped");
   chk_tmode_flag: assert property (testModeActive == (testModeCode != 2'h0)) else $error("test flag wrong");
   chk_hold_quiet: assert property (quietQ >= 4'h6 |-> $stable({localMaster68360, arbiterEnable, testModeCode,
      eepromLoadEnable})) else $error("capture moved");
   chk_proto_capture: assert property (($rose(pciResetn) ##1 $stable(burstInProgressStrapn)[*5])
      |-> localMaster68360 == !burstInProgressStrapn) else $error("protocol not captured");
   chk_arb_capture: assert property (($rose(localResetn) ##1 $stable(arbiterEnableStrap)[*5])
      |-> arbiterEnable == arbiterEnableStrap) else $error("arbiter not captured");
   chk_off_capture: assert property (($fell(hotSwapHealthyn) && hostPortOffStrap ##1 hostPortOffStrap[*5])
      |-> pciInterfaceOff) else $error("off status not set");
   chk_master_track: assert property ((!pciResetn && masterEnableStrap)[*5] |-> pciMasterEnable)
      else $error("master enable not set");
   chk_retry_cause: assert property (pciTargetRetry |-> $past(pciInterfaceOff)) else $error("retry while on");
   chk_retry_due: assert property ((pciInterfaceOff && pciTargetRequest)[*5] |-> pciTargetRetry)
      else $error("retry missing");
endmodule

// >>> rss_reset_strap_sampler_bench.sv
// Self-checking bench for the reset strap sampler
`timescale 1ns/1ps
module rss_reset_strap_sampler_bench;
   import rss_pkg::*;
   logic clk_sys = 0, resetn = 0, pciResetn = 1, localResetn = 1, hotSwapHealthyn = 0, pciTargetRequest = 0;
   logic [8:0] pick = 9'h000, straps;
   logic fitted = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, seed = 32'h0001_85f1, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, testModeCode, rsp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pciTargetRetry;
   logic localMaster68360, localSlave68360, testModeActive, pciMasterEnable, arbiterEnable, pciInterfaceOff;
   logic eepromLoadEnable;
   int n_errors = 0, checked = 0, e;
   int expq[$];
   rss_board_model u_board (.pick, .fitted, .straps);
   rss_reset_strap_sampler u_dut (.clk_sys, .resetn, .pciResetn, .localResetn, .hotSwapHealthyn,
      .burstInProgressStrapn(straps[RSS_F_BURST]), .sizeBit1Strap(straps[RSS_F_SIZE1]),
      .testModeSelect(straps[RSS_F_TMODE+:2]), .masterEnableStrap(straps[RSS_F_MEN]),
      .arbiterEnableStrap(straps[RSS_F_ARB]), .hostPortOffStrap(straps[RSS_F_OFF]),
      .serialDataStrap(straps[RSS_F_SDA]), .eepromLoadStrap(straps[RSS_F_EEP]), .pciTargetRequest,
      .pciTargetRetry, .localMaster68360, .localSlave68360, .testModeActive, .testModeCode, .pciMasterEnable,
      .arbiterEnable, .pciInterfaceOff, .eepromLoadEnable, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic results;
      $display("checked %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      checked++;
      if (g !== x) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, x, g);
      end
   endtask
   // One AXI4-Lite access; a lost answer ends the run
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      logic aw, wd, ar, fin;
      fin = 0;
      // A spare edge keeps back-to-back calls from driving one signal twice in a time step
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
      {s_axi_arvalid, s_axi_rready} <= {2{!w}};
      for (int i = 0; i < 40 && !fin; i++) begin
         @(negedge clk_sys);
         aw = s_axi_awvalid & s_axi_awready;
         wd = s_axi_wvalid & s_axi_wready;
         ar = s_axi_arvalid & s_axi_arready;
         fin = w ? s_axi_bvalid : s_axi_rvalid;
         rd = s_axi_rdata;
         rsp = w ? s_axi_bresp : s_axi_rresp;
         @(posedge clk_sys);
         if (aw) s_axi_awvalid <= 0;
         if (wd) s_axi_wvalid <= 0;
         if (ar) s_axi_arvalid <= 0;
         if (fin) {s_axi_bready, s_axi_rready} <= 2'h0;
      end
      if (!fin) begin
         n_errors++;
         results();
      end
   endtask
   // Kind 0 pulses PCI reset, 1 local reset, 2 hot-swap healthy
   task automatic trig(input int k);
      repeat (3) @(posedge clk_sys);
      pciResetn <= k != 0;
      localResetn <= k != 1;
      hotSwapHealthyn <= k == 2;
      repeat (6) @(posedge clk_sys);
      {pciResetn, localResetn, hotSwapHealthyn} <= 3'h6;
      repeat (8) @(posedge clk_sys);
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      resetn <= 1;
      @(posedge clk_sys);
      for (int n = 0; n < 12; n++) begin
         seed = xs(seed);
         bus(1, RSS_MISC_TWO_OFS, 32'h1);
         pick <= seed[8:0];
         fitted <= seed[9];
         trig(n % 3);
         e = (seed & 32'h19f) | (seed[9] ? 32'h60 : 0);
         expq.push_back(e);
         bus(0, RSS_STRAP_OFS, 0);
         chk("straps", e, rd);
         chk("read resp", RSS_RESP_OKAY, rsp);
         chk("master style", !e[0], localMaster68360);
         chk("slave style", 1, localSlave68360);
         chk("test code", e[8:7], testModeCode);
         chk("test on", e[8:7] != 0, testModeActive);
         chk("arbiter", e[3], arbiterEnable);
         chk("port off", e[4], pciInterfaceOff);
         chk("eeprom", e[5] & e[6], eepromLoadEnable);
         if (n % 3 == 0) chk("master en", e[2], pciMasterEnable);
         pick <= ~pick;
         fitted <= ~fitted;
         repeat (6) @(posedge clk_sys);
         bus(0, RSS_STRAP_OFS, 0);
         chk("held", expq.pop_front(), rd);
         bus(0, RSS_LIVE_OFS, 0);
         chk("live", (~seed & 32'h19f) | (seed[9] ? 32'h0 : 32'h60), rd);
         $display("trial %0d done", n);
      end
      pick <= 9'h010;
      trig(2);
      pciTargetRequest <= 1;
      repeat (6) @(posedge clk_sys);
      chk("retry", 1, pciTargetRetry);
      bus(0, RSS_MISC_TWO_OFS, 0);
      chk("off status", 1, rd);
      bus(1, RSS_MISC_TWO_OFS, 32'h1);
      repeat (4) @(posedge clk_sys);
      chk("retry", 0, pciTargetRetry);
      bus(0, RSS_MISC_TWO_OFS, 0);
      chk("off status", 0, rd);
      pciTargetRequest <= 0;
      pick <= 9'h000;
      trig(0);
      chk("master en", 0, pciMasterEnable);
      bus(1, RSS_COMMAND_OFS, 32'h4);
      chk("write resp", RSS_RESP_OKAY, rsp);
      chk("master en", 1, pciMasterEnable);
      bus(0, 32'h10, 0);
      chk("unmapped", {30'h0, RSS_RESP_SLVERR}, {rd[29:0], rsp});
      $display("register tests done");
      results();
   end
endmodule
bind rss_reset_strap_sampler rss_strap_sva u_chk (.clk_sys, .resetn, .pciResetn, .localResetn, .hotSwapHealthyn,
   .burstInProgressStrapn, .masterEnableStrap, .arbiterEnableStrap, .hostPortOffStrap, .pciTargetRequest,
   .pciTargetRetry, .localMaster68360, .localSlave68360, .testModeActive, .testModeCode, .pciMasterEnable,
   .arbiterEnable, .pciInterfaceOff, .eepromLoadEnable);
